// ===== src/axis_pwm_pulse_output.v
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_defs.vh"

module axis_pwm_pulse_output #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Axis motion side
  input wire axis_x_busy,
  input wire axis_y_busy,
  input wire move_cmd,
  input wire decel_stop_command,
  input wire emergency_stop_command,
  input wire upper_limit,
  input wire lower_limit,
  input wire [31:0] pos_in,
  // Outputs
  output reg pulse_x,
  output reg pulse_y,
  output reg [31:0] position_r,
  output reg limit_fault_r,
  output reg motion_start_r,
  output reg stop_seen_r
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state_r;
  reg en_r;
  reg axis_r;
  reg run_axis_r;
  reg err_x_r;
  reg err_y_r;
  reg [15:0] period_r;
  reg [7:0] duty_r;
  reg [15:0] run_period_r;
  reg [15:0] off_ms_r;
  reg [15:0] ms_cnt_r;
  reg out_r;
  reg cspd_x_r;
  reg busy_x_r;
  reg cspd_y_r;
  reg busy_y_r;
  reg refused_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [31:0] rd_word;
  wire tick;
  wire running;
  wire axis_busy;
  wire axis_err;
  wire addr_ok;
  wire wr_req;
  wire rd_req;
  wire start_ok;
  wire start_on;
  wire wrap_on;
  wire period_end;
  wire [15:0] cnt_inc;
  wire [15:0] on_ms;
  wire [23:0] off_prod;
  wire [23:0] off_quot;
  wire [15:0] off_ms;

  // ----------------------------------------
  // Start conditions
  // ----------------------------------------
  assign running = (state_r == ST_RUN);
  assign axis_busy = axis_r ? axis_y_busy : axis_x_busy;
  assign axis_err = axis_r ? err_y_r : err_x_r;
  // A refusal sticks until enable drops, so a busy axis cannot slip in later
  assign start_ok = en_r && !axis_busy && !axis_err && !refused_r;

  // ----------------------------------------
  // Phase arithmetic
  // ----------------------------------------
  // Off time truncates toward zero; the largest in-range quotient still fits 16 bits
  assign off_prod = {8'h00, period_r} * {16'h0000, duty_r};
  assign off_quot = off_prod / `PCT_FULL;
  assign off_ms = off_quot[15:0];
  // Full-off duty never shows an on phase, not even the first one
  assign start_on = (off_ms != period_r);
  assign wrap_on = (off_ms_r != run_period_r);
  // Count after this tick, and where the on phase gives way to off
  assign cnt_inc = ms_cnt_r + 16'h0001;
  assign period_end = (cnt_inc >= run_period_r);
  assign on_ms = run_period_r - off_ms_r;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  // Only NONSEQ opens a transfer; hsize is ignored, every register is a word
  assign addr_ok = hsel && hready && (htrans == `HTRANS_NONSEQ);
  assign wr_req = addr_ok && hwrite;
  assign rd_req = addr_ok && !hwrite;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Looked up in the address phase, registered into the data phase
  always @* begin
    rd_word = 32'h00000000;
    case (haddr)
      `OFF_CTRL: begin
        rd_word[`CTRL_EN_BIT] = en_r;
        rd_word[`CTRL_AXIS_BIT] = axis_r;
        rd_word[`CTRL_ERRX_BIT] = err_x_r;
        rd_word[`CTRL_ERRY_BIT] = err_y_r;
      end
      `OFF_PERIOD: rd_word[15:0] = period_r;
      `OFF_DUTY: rd_word[7:0] = duty_r;
      `OFF_STATUS: begin
        rd_word[`ST_OUT_BIT] = out_r;
        rd_word[`ST_CSPD_X_BIT] = cspd_x_r;
        rd_word[`ST_BUSY_X_BIT] = busy_x_r;
        rd_word[`ST_CSPD_Y_BIT] = cspd_y_r;
        rd_word[`ST_BUSY_Y_BIT] = busy_y_r;
        rd_word[`ST_REFUSED_BIT] = refused_r;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // Writes land one cycle after the address phase, when hwdata is valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      en_r <= 1'b0;
      axis_r <= 1'b0;
      err_x_r <= 1'b0;
      err_y_r <= 1'b0;
      period_r <= `PERIOD_RST;
      duty_r <= `DUTY_RST;
    end else begin
      wr_pend_r <= wr_req;
      // Address kept for the data phase of a write
      if (addr_ok) begin
        wr_addr_r <= haddr;
      end
      if (wr_pend_r) begin
        case (wr_addr_r)
          `OFF_CTRL: begin
            en_r <= hwdata[`CTRL_EN_BIT];
            axis_r <= hwdata[`CTRL_AXIS_BIT];
            err_x_r <= hwdata[`CTRL_ERRX_BIT];
            err_y_r <= hwdata[`CTRL_ERRY_BIT];
          end
          // Software must keep values in range; no clamping here
          `OFF_PERIOD: period_r <= hwdata[15:0];
          `OFF_DUTY: duty_r <= hwdata[7:0];
          default: ;
        endcase
      end
      // Read data stands for the data phase only, then drops back to zero
      hrdata <= rd_req ? rd_word : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Pulse engine
  // ----------------------------------------
  // Stop commands are deliberately not inputs to this process
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      run_axis_r <= 1'b0;
      run_period_r <= `PERIOD_RST;
      off_ms_r <= 16'h0000;
      ms_cnt_r <= 16'h0000;
      out_r <= 1'b0;
      cspd_x_r <= 1'b0;
      busy_x_r <= 1'b0;
      cspd_y_r <= 1'b0;
      busy_y_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          out_r <= 1'b0;
          // Enable seen low clears any refusal so software can retry
          if (!en_r) begin
            refused_r <= 1'b0;
          end else if (axis_busy || axis_err) begin
            refused_r <= 1'b1;
          end else if (start_ok) begin
            // Period, off time and axis frozen for the whole run
            run_period_r <= period_r;
            off_ms_r <= off_ms;
            ms_cnt_r <= 16'h0000;
            out_r <= start_on;
            run_axis_r <= axis_r;
            cspd_x_r <= !axis_r;
            busy_x_r <= !axis_r;
            cspd_y_r <= axis_r;
            busy_y_r <= axis_r;
            state_r <= ST_RUN;
          end
        end
        // Dropping enable wins over a pending tick
        ST_RUN: begin
          if (!en_r) begin
            out_r <= 1'b0;
            cspd_x_r <= 1'b0;
            busy_x_r <= 1'b0;
            cspd_y_r <= 1'b0;
            busy_y_r <= 1'b0;
            state_r <= ST_IDLE;
          end else if (tick) begin
            // On for period minus off, then off until period ends
            if (period_end) begin
              ms_cnt_r <= 16'h0000;
              out_r <= wrap_on;
            end else begin
              ms_cnt_r <= cnt_inc;
              out_r <= (cnt_inc < on_ms);
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Axis outputs and motion gating
  // ----------------------------------------
  // Position tracks the counter only while idle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_x <= 1'b0;
      pulse_y <= 1'b0;
      position_r <= 32'h00000000;
      limit_fault_r <= 1'b0;
      motion_start_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      // Routed by the latched axis so a control write cannot move the train
      pulse_x <= out_r && running && !run_axis_r;
      pulse_y <= out_r && running && run_axis_r;
      if (!running) begin
        position_r <= pos_in;
      end
      // Limits and other commands only reach the axis while idle
      limit_fault_r <= !running && (upper_limit || lower_limit);
      motion_start_r <= !running && move_cmd;
      stop_seen_r <= !running && (decel_stop_command || emergency_stop_command);
    end
  end

endmodule // axis_pwm_pulse_output

`default_nettype wire

// ===== src/pwm_defs.vh
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_DUTY 8'h08
`define OFF_STATUS 8'h0c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_AXIS_BIT 1
`define CTRL_ERRX_BIT 2
`define CTRL_ERRY_BIT 3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_OUT_BIT 0
`define ST_CSPD_X_BIT 1
`define ST_BUSY_X_BIT 2
`define ST_CSPD_Y_BIT 3
`define ST_BUSY_Y_BIT 4
`define ST_REFUSED_BIT 5

// ----------------------------------------
// Setting limits and reset values
// ----------------------------------------
`define PERIOD_MIN 16'h0001
`define PERIOD_MAX 16'h4e20
`define DUTY_MIN 8'h01
`define DUTY_MAX 8'h64
`define PERIOD_RST 16'h01f4
`define DUTY_RST 8'h1e
`define PCT_FULL 24'h000064

// ----------------------------------------
// Time base: 1 ms at 40 MHz
// ----------------------------------------
`define TICK_MS 1
`define CLK_KHZ 40000
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)

// ----------------------------------------
// AHB encodings
// ----------------------------------------
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY 1'b0

`endif

// ===== src/ms_tick.v
`timescale 1ns/10ps
`default_nettype none
`include "pwm_defs.vh"

// Millisecond strobe, one cycle wide, free running
module ms_tick #(
  parameter CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Strobe
  output reg tick
);

  localparam integer LAST_I = CYCLES - 1;
  localparam [15:0] LAST = LAST_I[15:0];
  reg [15:0] cnt_r;

  // Counter wraps every millisecond
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == LAST);
      if (cnt_r == LAST) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

endmodule // ms_tick

`default_nettype wire

// ===== test/pwm_props.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checks
// ----------------------------------------
module pwm_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Axis side
  input wire logic pulse_x,
  input wire logic pulse_y,
  input wire logic [31:0] position_r,
  input wire logic limit_fault_r,
  input wire logic motion_start_r,
  input wire logic stop_seen_r
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A visible pulse means the engine ran one cycle earlier
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_okay_resp: assert property (!hresp) else $error("hresp not okay");
  a_one_axis: assert property (!(pulse_x && pulse_y)) else $error("both axes");
  a_no_motion: assert property ((pulse_x || pulse_y) |-> !motion_start_r)
    else $error("motion start while running");
  a_no_limit: assert property ((pulse_x || pulse_y) |-> !limit_fault_r)
    else $error("limit fault while running");
  a_no_stop: assert property ((pulse_x || pulse_y) |-> !stop_seen_r)
    else $error("stop seen while running");
  a_pos_frozen: assert property ((pulse_x && $past(pulse_x)) |-> $stable(position_r))
    else $error("position moved while running");
  a_rdata_idle: assert property (!(hsel && hready && htrans == 2'b10 && !hwrite)
    |=> hrdata == 32'h0) else $error("read data not cleared");
endmodule // pwm_props
`default_nettype wire

// ===== test/pwm_load.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Pulse-driven load, measures phase widths
// ----------------------------------------
module pwm_load (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Drive from the block
  input wire logic pulse,
  // Last completed widths, in cycles
  output logic [15:0] on_len,
  output logic [15:0] off_len
);
  logic [15:0] run_r;
  logic last_r;
  // Only whole phases count; the first phase may be cut by tick phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 16'h0;
      last_r <= 1'b0;
      on_len <= 16'h0;
      off_len <= 16'h0;
    end else begin
      last_r <= pulse;
      run_r <= (pulse !== last_r) ? 16'h1 : run_r + 16'h1;
      if (pulse !== last_r && last_r) on_len <= run_r;
      if (pulse !== last_r && !last_r) off_len <= run_r;
    end
  end
endmodule // pwm_load
`default_nettype wire

// ===== test/axis_pwm_pulse_output_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module axis_pwm_pulse_output_bench;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, pos_in = 32'h1234, position_r, junk;
  logic xb = 1'b0, yb = 1'b0, mv = 1'b0, dst = 1'b0, est = 1'b0, ul = 1'b0, ll = 1'b0;
  logic pulse_x, pulse_y, limit_fault_r, motion_start_r, stop_seen_r;
  logic [15:0] on_len, off_len;
  int errors = 0, n_checks = 0, cyc = 0;
  axis_pwm_pulse_output #(.TICK_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .axis_x_busy(xb), .axis_y_busy(yb), .move_cmd(mv),
    .decel_stop_command(dst), .emergency_stop_command(est), .upper_limit(ul),
    .lower_limit(ll), .pos_in(pos_in), .pulse_x(pulse_x), .pulse_y(pulse_y),
    .position_r(position_r), .limit_fault_r(limit_fault_r),
    .motion_start_r(motion_start_r), .stop_seen_r(stop_seen_r));
  pwm_load load (.hclk(hclk), .hresetn(hresetn), .pulse(pulse_x | pulse_y),
    .on_len(on_len), .off_len(off_len));
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Single AHB-Lite word transfer; waits on hready in both phases
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, junk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(n, e, r & m);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h04, 32'h1f4, 32'hffff, "period reset");
    rd(8'h08, 32'h1e, 32'hff, "duty reset");
    rd(8'h10, 32'h0, 32'hffffffff, "unmapped");
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h28);
    wr(8'h00, 32'h1);
    {mv, dst, est, ul, ll} <= 5'h1f;
    repeat (4) @(posedge hclk);
    pos_in <= 32'h55;
    repeat (56) @(posedge hclk);
    chk("position", 32'h1234, position_r);
    rd(8'h0c, 32'h6, 32'h1e, "status x");
    wr(8'h04, 32'h2);
    repeat (60) @(posedge hclk);
    chk("on x", 32'hc, 32'(on_len));
    chk("off x", 32'h8, 32'(off_len));
    wr(8'h00, 32'h0);
    repeat (3) @(posedge hclk);
    chk("pulse off", 32'h0, 32'(pulse_x));
    chk("start seen", 32'h1, 32'(motion_start_r));
    chk("limit seen", 32'h1, 32'(limit_fault_r));
    chk("stop seen", 32'h1, 32'(stop_seen_r));
    rd(8'h0c, 32'h0, 32'h1f, "status idle");
    {mv, dst, est, ul, ll} <= 5'h0;
    xb <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (10) @(posedge hclk);
    chk("busy refuse", 32'h0, 32'(pulse_x));
    rd(8'h0c, 32'h20, 32'h3f, "refused");
    wr(8'h00, 32'h0);
    xb <= 1'b0;
    wr(8'h00, 32'h5);
    repeat (10) @(posedge hclk);
    chk("error refuse", 32'h0, 32'(pulse_x));
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h32);
    wr(8'h00, 32'h3);
    repeat (40) @(posedge hclk);
    rd(8'h0c, 32'h18, 32'h1e, "status y");
    chk("on y", 32'h8, 32'(on_len));
    chk("off y", 32'h4, 32'(off_len));
    wr(8'h00, 32'h0);
    wrap_up;
  end
endmodule // axis_pwm_pulse_output_bench

bind axis_pwm_pulse_output pwm_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pulse_x(pulse_x), .pulse_y(pulse_y),
  .position_r(position_r), .limit_fault_r(limit_fault_r),
  .motion_start_r(motion_start_r), .stop_seen_r(stop_seen_r));
`default_nettype wire
